// File: lcdb_ctrl.sv
/*
 Continuous-drive and brake controller: register file, playback sequencer,
 drive level and brake gain selection, detected-frequency readback.
 Assumes register strobes and all inputs synchronous to clock_i, and that the
 tracking loop supplies its half period in clock cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module lcdb_ctrl #(
    parameter int DRV_UNIT_CYC_P = lcdb_pkg::DRV_UNIT_CYC
) (
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_we_i,
    input  wire logic                 reg_re_i,
    output logic      [7:0]           reg_rdata_o,
    input  wire lcdb_pkg::lcdb_supply_t supply_i,
    input  wire logic                 resonance_detect_enable_i,
    input  wire logic                 meas_valid_i,
    input  wire logic [15:0]          meas_count_i,
    input  wire logic [19:0]          tracked_half_cyc_i,
    input  wire logic                 play_i,
    output lcdb_pkg::lcdb_phase_t     phase_o,
    output logic                      drive_pol_o,
    output logic      [7:0]           drive_level_o,
    output logic      [3:0]           brake_gain_o,
    output logic                      busy_o,
    output logic      [19:0]          preset_half_cyc_o,
    output logic      [15:0]          track_margin_cyc_o,
    output logic                      detect_active_o
);
    import lcdb_pkg::*;

    lcdb_cfg_t   cfg_q;
    logic [7:0]  freq_hi_q;
    logic [7:0]  freq_lo_q;
    lcdb_phase_t state_q;
    logic [7:0]  half_left_q;
    logic [7:0]  len_loaded_q;
    logic [7:0]  halves_seen_q;
    logic        tmr_start;
    logic        tmr_busy;
    logic        tmr_done;
    logic [19:0] tmr_len;
    logic [19:0] width_cyc;

    // Drive voltage code for one phase level under the current supply mode
    function automatic logic [7:0] phase_volt(input logic [6:0] lvl, input lcdb_supply_t s);
        logic [14:0] p_rail;
        logic [14:0] p_ref;
        logic [14:0] lim;
        begin
            p_rail = 15'(s.supply_rail * lvl);
            p_ref  = 15'(s.vbat_ref * lvl);
            lim    = {s.vbat, 7'h00};
            if (!s.vbat_comp || s.boost_select) begin
                phase_volt = p_rail[14:7];
            end else if (p_ref > lim) begin
                phase_volt = s.supply_rail;
            end else begin
                phase_volt = p_ref[14:7];
            end
        end
    endfunction : phase_volt

    // Register writes; the read-only frequency bytes ignore writes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= '{RST_PRESET, RST_HWIDTH, RST_BST_GAIN, RST_PLN_GAIN, RST_TRACK_EN,
                       RST_LVL1, RST_LVL2, RST_CNT1, RST_CNT2, RST_CNTBRK, RST_MARGIN};
        end else if (reg_we_i) begin
            case (reg_addr_i)
                ADR_PRESET:  cfg_q.preset_resonance_code <= reg_wdata_i;
                ADR_HWIDTH:  cfg_q.half_width_code <= reg_wdata_i;
                ADR_BRKGAIN: begin
                    cfg_q.boosted_brake_gain <= reg_wdata_i[7:BST_GAIN_LSB];
                    cfg_q.plain_brake_gain   <= reg_wdata_i[BST_GAIN_LSB-1:0];
                end
                ADR_TRKLVL1: begin
                    cfg_q.track_en          <= reg_wdata_i[TRACK_EN_BIT];
                    cfg_q.first_phase_level <= reg_wdata_i[6:0];
                end
                ADR_LVL2:    cfg_q.second_phase_level <= reg_wdata_i[6:0];
                ADR_CNT1:    cfg_q.first_phase_count <= reg_wdata_i;
                ADR_CNT2:    cfg_q.second_phase_count <= reg_wdata_i;
                ADR_CNTBRK:  cfg_q.brake_count <= reg_wdata_i;
                ADR_MARGIN:  cfg_q.tracking_margin <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses and the spare bit read zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                ADR_PRESET:  reg_rdata_o <= cfg_q.preset_resonance_code;
                ADR_HWIDTH:  reg_rdata_o <= cfg_q.half_width_code;
                ADR_BRKGAIN: reg_rdata_o <= {cfg_q.boosted_brake_gain, cfg_q.plain_brake_gain};
                ADR_TRKLVL1: reg_rdata_o <= {cfg_q.track_en, cfg_q.first_phase_level};
                ADR_LVL2:    reg_rdata_o <= {1'b0, cfg_q.second_phase_level};
                ADR_CNT1:    reg_rdata_o <= cfg_q.first_phase_count;
                ADR_CNT2:    reg_rdata_o <= cfg_q.second_phase_count;
                ADR_CNTBRK:  reg_rdata_o <= cfg_q.brake_count;
                ADR_MARGIN:  reg_rdata_o <= cfg_q.tracking_margin;
                ADR_FREQ_HI: reg_rdata_o <= freq_hi_q;
                ADR_FREQ_LO: reg_rdata_o <= freq_lo_q;
                default:     reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Both bytes load in one edge; a capture landing between a high and a low read still gives bytes of two results
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            freq_hi_q <= 8'h00;
            freq_lo_q <= 8'h00;
        end else if (meas_valid_i && resonance_detect_enable_i) begin
            freq_hi_q <= meas_count_i[15:8];
            freq_lo_q <= meas_count_i[7:0];
        end
    end

    // Half-width in clock cycles; the unit is rounded down to whole cycles
    assign width_cyc = 20'(int'(cfg_q.half_width_code) * DRV_UNIT_CYC_P);
    always_comb begin
        if (state_q != LCDB_BRAKE && cfg_q.track_en) begin
            tmr_len = tracked_half_cyc_i;
        end else begin
            tmr_len = width_cyc;
        end
    end
    assign tmr_start = (state_q != LCDB_IDLE) && (half_left_q != 8'h00) && !tmr_busy && !tmr_done;

    lcdb_half_timer u_timer (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .start_i (tmr_start),
        .len_i   (tmr_len),
        .busy_o  (tmr_busy),
        .done_o  (tmr_done)
    );

    // Phase sequencer; a phase whose count is zero is skipped in one cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q      <= LCDB_IDLE;
            half_left_q  <= 8'h00;
            len_loaded_q <= 8'h00;
        end else begin
            case (state_q)
                LCDB_IDLE: begin
                    if (play_i) begin
                        state_q      <= LCDB_DRV1;
                        half_left_q  <= cfg_q.first_phase_count;
                        len_loaded_q <= cfg_q.first_phase_count;
                    end
                end
                default: begin
                    if (tmr_done) begin
                        half_left_q <= half_left_q - 8'h01;
                    end else if (half_left_q == 8'h00 && !tmr_busy) begin
                        case (state_q)
                            LCDB_DRV1: begin
                                state_q      <= LCDB_DRV2;
                                half_left_q  <= cfg_q.second_phase_count;
                                len_loaded_q <= cfg_q.second_phase_count;
                            end
                            LCDB_DRV2: begin
                                state_q      <= LCDB_BRAKE;
                                half_left_q  <= cfg_q.brake_count;
                                len_loaded_q <= cfg_q.brake_count;
                            end
                            default: state_q <= LCDB_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // Registered drive outputs; polarity flips at each finished half-cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase_o       <= LCDB_IDLE;
            drive_pol_o   <= 1'b0;
            drive_level_o <= 8'h00;
            brake_gain_o  <= 4'h0;
            busy_o        <= 1'b0;
        end else begin
            phase_o      <= state_q;
            busy_o       <= (state_q != LCDB_IDLE);
            brake_gain_o <= supply_i.boost_select ? cfg_q.boosted_brake_gain
                                                  : cfg_q.plain_brake_gain;
            if (state_q == LCDB_IDLE) begin
                drive_pol_o <= 1'b0;
            end else if (tmr_done) begin
                drive_pol_o <= ~drive_pol_o;
            end
            case (state_q)
                LCDB_DRV1: drive_level_o <= phase_volt(cfg_q.first_phase_level, supply_i);
                LCDB_DRV2: drive_level_o <= phase_volt(cfg_q.second_phase_level, supply_i);
                default:   drive_level_o <= 8'h00;
            endcase
        end
    end

    // Preset half period and margin handed to the tracking loop in clock cycles
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            preset_half_cyc_o  <= 20'h00000;
            track_margin_cyc_o <= 16'h0000;
            detect_active_o    <= 1'b0;
        end else begin
            preset_half_cyc_o  <= 20'(int'(cfg_q.preset_resonance_code) * DRV_UNIT_CYC_P);
            track_margin_cyc_o <= 16'(int'(cfg_q.tracking_margin) * MARGIN_UNIT_CYC);
            detect_active_o    <= resonance_detect_enable_i;
        end
    end

    // Helper: half-cycles finished in the current phase, for checking only
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            halves_seen_q <= 8'h00;
        end else if (state_q == LCDB_IDLE || half_left_q == 8'h00 && !tmr_busy && !tmr_done) begin
            halves_seen_q <= 8'h00;
        end else if (tmr_done) begin
            halves_seen_q <= halves_seen_q + 8'h01;
        end
    end

    property p_brake_gain;
        @(posedge clock_i) disable iff (rst_i)
        1'b1 |=> brake_gain_o == ($past(supply_i.boost_select) ? $past(cfg_q.boosted_brake_gain)
                                                        : $past(cfg_q.plain_brake_gain));
    endproperty
    a_brake_gain: assert property (p_brake_gain) else $error("brake gain wrong");

    property p_det_hold;
        @(posedge clock_i) disable iff (rst_i)
        !resonance_detect_enable_i |=> $stable(freq_hi_q) && $stable(freq_lo_q);
    endproperty
    a_det_hold: assert property (p_det_hold) else $error("frequency changed while idle");

    property p_det_pair;
        @(posedge clock_i) disable iff (rst_i)
        meas_valid_i && resonance_detect_enable_i |=> {freq_hi_q, freq_lo_q} == $past(meas_count_i);
    endproperty
    a_det_pair: assert property (p_det_pair) else $error("frequency pair not captured");

    property p_order1;
        @(posedge clock_i) disable iff (rst_i)
        state_q == LCDB_DRV1 ##1 state_q != LCDB_DRV1 |-> state_q == LCDB_DRV2;
    endproperty
    a_order1: assert property (p_order1) else $error("first phase not followed by second");

    property p_order2;
        @(posedge clock_i) disable iff (rst_i)
        state_q == LCDB_DRV2 ##1 state_q != LCDB_DRV2 |-> state_q == LCDB_BRAKE;
    endproperty
    a_order2: assert property (p_order2) else $error("second phase not followed by brake");

    property p_count;
        @(posedge clock_i) disable iff (rst_i)
        state_q != LCDB_IDLE ##1 $changed(state_q) |-> $past(halves_seen_q) == $past(len_loaded_q);
    endproperty
    a_count: assert property (p_count) else $error("half-cycle count wrong");

    property p_clamp;
        @(posedge clock_i) disable iff (rst_i)
        state_q == LCDB_DRV1 && supply_i.vbat_comp && !supply_i.boost_select &&
        (15'(supply_i.vbat_ref * cfg_q.first_phase_level) > {supply_i.vbat, 7'h00})
        |=> drive_level_o == $past(supply_i.supply_rail);
    endproperty
    a_clamp: assert property (p_clamp) else $error("compensated level not clamped");

    property p_level2;
        @(posedge clock_i) disable iff (rst_i)
        state_q == LCDB_DRV2 && !supply_i.vbat_comp
        |=> drive_level_o == 8'((16'($past(supply_i.supply_rail))
                                 * $past(cfg_q.second_phase_level)) >> 7);
    endproperty
    a_level2: assert property (p_level2) else $error("second level wrong");

    property p_width;
        @(posedge clock_i) disable iff (rst_i)
        tmr_start && (state_q == LCDB_BRAKE || !cfg_q.track_en)
        |-> tmr_len == 20'(int'(cfg_q.half_width_code) * DRV_UNIT_CYC_P);
    endproperty
    a_width: assert property (p_width) else $error("half-width length wrong");

    property p_track;
        @(posedge clock_i) disable iff (rst_i)
        tmr_start && state_q != LCDB_BRAKE && cfg_q.track_en |-> tmr_len == tracked_half_cyc_i;
    endproperty
    a_track: assert property (p_track) else $error("tracked length not used");
endmodule : lcdb_ctrl
`default_nettype wire

// File: lcdb_half_timer.sv
/*
 Half-cycle timer: counts one half-cycle of the given length in clock cycles.
 Assumes the caller only starts it while busy_o and done_o are both low.
*/
`timescale 1ns/10ps
`default_nettype none
module lcdb_half_timer (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [19:0] len_i,
    output logic             busy_o,
    output logic             done_o
);
    logic [19:0] cnt_q;

    // A zero length is stretched to one cycle so the sequencer never hangs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 20'h00000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q  <= (len_i == 20'h00000) ? 20'h00000 : len_i - 20'h00001;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_q == 20'h00000) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 20'h00001;
                end
            end
        end
    end
endmodule : lcdb_half_timer
`default_nettype wire

// File: lcdb_lra_model.sv
/*
 Actuator-side model: answers measurement requests, supplies a steady tracked
 half period, and watches polarity, level and half-cycle spacing per phase.
 Assumes the controller's clock and reset; requests come from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module lcdb_lra_model #(
    parameter logic [19:0] TRACK_HALF_P = 20'h9
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic                  meas_req_i,
    input  wire logic [15:0]           meas_val_i,
    input  wire lcdb_pkg::lcdb_phase_t phase_i,
    input  wire logic                  pol_i,
    input  wire logic [7:0]            level_i,
    output logic                       meas_valid_o,
    output logic      [15:0]           meas_count_o,
    output logic      [19:0]           tracked_half_o,
    output logic      [3:0][7:0]       halves_o,
    output logic      [3:0][7:0]       lvl_o,
    output logic      [15:0]           gap_drv_o,
    output logic      [15:0]           gap_brk_o
);
    import lcdb_pkg::*;
    logic        pol_q;
    lcdb_phase_t prev_ph_q;
    lcdb_phase_t last_ph_q;
    logic [15:0] cyc_q;

    // A settled tracking loop reports one constant half period
    assign tracked_half_o = TRACK_HALF_P;

    // One pulse per request; the count is scrambled between pulses so a stale value is caught
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meas_valid_o <= 1'b0;
            meas_count_o <= 16'h0;
        end else begin
            meas_valid_o <= meas_req_i;
            meas_count_o <= meas_req_i ? meas_val_i : ~meas_count_o;
        end
    end

    // Toggles are charged to the phase shown when they appear; gaps only within one phase
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pol_q     <= 1'b0;
            prev_ph_q <= LCDB_IDLE;
            last_ph_q <= LCDB_IDLE;
            cyc_q     <= 16'h0;
            halves_o  <= '0;
            lvl_o     <= '0;
            gap_drv_o <= 16'h0;
            gap_brk_o <= 16'h0;
        end else begin
            prev_ph_q <= phase_i;
            pol_q     <= pol_i;
            cyc_q     <= cyc_q + 16'h1;
            if (prev_ph_q == LCDB_IDLE && phase_i != LCDB_IDLE) begin
                halves_o <= '0;
                lvl_o    <= '0;
            end else if (phase_i != LCDB_IDLE) begin
                if (level_i > lvl_o[phase_i]) begin
                    lvl_o[phase_i] <= level_i;
                end
                if (pol_i != pol_q) begin
                    halves_o[phase_i] <= halves_o[phase_i] + 8'h1;
                    cyc_q             <= 16'h1;
                    last_ph_q         <= phase_i;
                    if (last_ph_q == phase_i && phase_i == LCDB_BRAKE) begin
                        gap_brk_o <= cyc_q;
                    end else if (last_ph_q == phase_i) begin
                        gap_drv_o <= cyc_q;
                    end
                end
            end
        end
    end
endmodule : lcdb_lra_model
`default_nettype wire

// File: lcdb_pkg.sv
/*
 Constants, register map and carrier types for the continuous-drive and brake
 controller of a resonant-actuator haptic driver.
 Assumes a single 100 MHz clock and an 8-bit register port in the parent.
*/
// Behaviour
// - Preset resonant frequency is 24 kHz over an 8-bit code, reset 0x8D.
// - Each brake half-cycle lasts the half-width code over 48000 seconds.
// - Tracking off uses half-width for drive half-cycles; on (reset) uses tracked period.
// - Brake gain is bits 7:4 when boosted, bits 3:0 otherwise.
// - Battery compensation gives reference times level over 128.
// - Compensated output clamps to the rail when reference times level over battery exceeds 128.
// - Without compensation or when boosted, output is rail times level over 128.
// - Second phase uses the same formulas with its own level, reset 0x50.
// - First drive phase lasts its 8-bit half-cycle count, reset 4.
// - Second drive phase lasts its own 8-bit half-cycle count, reset 6.
// - Brake lasts its 8-bit half-cycle count, reset 8.
// - Tracking margin is 8 bits in units of 1/480000 s, reset 12.
// - Detected frequency is a 16-bit read-only count split into two bytes.
// - Detection runs only while its enable is 1; enable resets to 0.
package lcdb_pkg;
    localparam int CLK_HZ        = 100_000_000;
    localparam int DRV_UNIT_HZ   = 48000;
    localparam int MARGIN_UNIT_HZ = 480000;
    localparam int DRV_UNIT_CYC  = CLK_HZ / DRV_UNIT_HZ;
    localparam int MARGIN_UNIT_CYC = CLK_HZ / MARGIN_UNIT_HZ;

    localparam logic [7:0] ADR_PRESET   = 8'h19;
    localparam logic [7:0] ADR_HWIDTH   = 8'h1a;
    localparam logic [7:0] ADR_BRKGAIN  = 8'h1c;
    localparam logic [7:0] ADR_TRKLVL1  = 8'h1d;
    localparam logic [7:0] ADR_LVL2     = 8'h1e;
    localparam logic [7:0] ADR_CNT1     = 8'h1f;
    localparam logic [7:0] ADR_CNT2     = 8'h20;
    localparam logic [7:0] ADR_CNTBRK   = 8'h21;
    localparam logic [7:0] ADR_MARGIN   = 8'h22;
    localparam logic [7:0] ADR_FREQ_HI  = 8'h25;
    localparam logic [7:0] ADR_FREQ_LO  = 8'h26;

    localparam logic [7:0] RST_PRESET   = 8'h8d;
    localparam logic [7:0] RST_HWIDTH   = 8'h6a;
    localparam logic [3:0] RST_BST_GAIN = 4'h5;
    localparam logic [3:0] RST_PLN_GAIN = 4'h8;
    localparam logic       RST_TRACK_EN = 1'b1;
    localparam logic [6:0] RST_LVL1     = 7'h7f;
    localparam logic [6:0] RST_LVL2     = 7'h50;
    localparam logic [7:0] RST_CNT1     = 8'h04;
    localparam logic [7:0] RST_CNT2     = 8'h06;
    localparam logic [7:0] RST_CNTBRK   = 8'h08;
    localparam logic [7:0] RST_MARGIN   = 8'h0c;

    localparam int BST_GAIN_LSB = 4;
    localparam int TRACK_EN_BIT = 7;
    localparam int LEVEL_FULL   = 128;

    typedef enum logic [1:0] {
        LCDB_IDLE,
        LCDB_DRV1,
        LCDB_DRV2,
        LCDB_BRAKE
    } lcdb_phase_t;

    typedef struct packed {
        logic [7:0] preset_resonance_code;
        logic [7:0] half_width_code;
        logic [3:0] boosted_brake_gain;
        logic [3:0] plain_brake_gain;
        logic       track_en;
        logic [6:0] first_phase_level;
        logic [6:0] second_phase_level;
        logic [7:0] first_phase_count;
        logic [7:0] second_phase_count;
        logic [7:0] brake_count;
        logic [7:0] tracking_margin;
    } lcdb_cfg_t;

    typedef struct packed {
        logic [7:0] supply_rail;
        logic [7:0] vbat_ref;
        logic [7:0] vbat;
        logic       boost_select;
        logic       vbat_comp;
    } lcdb_supply_t;
endpackage : lcdb_pkg

// File: tb_top.sv
/*
 Self-checking bench: register port, measurement capture and three playbacks.
 Assumes the package constants and a 100 MHz clock; half-width unit shortened.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import lcdb_pkg::*;
    localparam int UNIT = 4;
    localparam logic [7:0] RA [11] = '{ADR_PRESET, ADR_HWIDTH, ADR_BRKGAIN, ADR_TRKLVL1,
        ADR_LVL2, ADR_CNT1, ADR_CNT2, ADR_CNTBRK, ADR_MARGIN, ADR_FREQ_HI, ADR_FREQ_LO};
    localparam logic [7:0] RV [11] = '{8'h8d, 8'h6a, 8'h58, 8'hff, 8'h50, 8'h04, 8'h06,
        8'h08, 8'h0c, 8'h00, 8'h00};
    logic clock_i, rst_i, we, re, det_en, mvalid, play, pol, busy, det_act, mreq;
    logic [7:0]      addr, wdata, rdata, level;
    logic [15:0]     mcount, mval, margin_cyc, gap_drv, gap_brk;
    logic [19:0]     tracked, preset_cyc;
    logic [3:0]      gain;
    logic [3:0][7:0] halves, lvl;
    lcdb_supply_t    supply;
    lcdb_phase_t     phase;
    int              err_total = 0;
    int              checked = 0;

    lcdb_ctrl #(.DRV_UNIT_CYC_P(UNIT)) i_lcdb_ctrl (.clock_i(clock_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .supply_i(supply), .resonance_detect_enable_i(det_en),
        .meas_valid_i(mvalid), .meas_count_i(mcount), .tracked_half_cyc_i(tracked),
        .play_i(play), .phase_o(phase), .drive_pol_o(pol), .drive_level_o(level),
        .brake_gain_o(gain), .busy_o(busy), .preset_half_cyc_o(preset_cyc),
        .track_margin_cyc_o(margin_cyc), .detect_active_o(det_act));
    lcdb_lra_model i_lcdb_lra_model (.clock_i(clock_i), .rst_i(rst_i), .meas_req_i(mreq),
        .meas_val_i(mval), .phase_i(phase), .pol_i(pol), .level_i(level),
        .meas_valid_o(mvalid), .meas_count_o(mcount), .tracked_half_o(tracked),
        .halves_o(halves), .lvl_o(lvl), .gap_drv_o(gap_drv), .gap_brk_o(gap_brk));

    // Free-running clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Every task starts and ends 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        we    = 1'b1;
        tick(1);
        we = 1'b0;
        tick(1); // Idle edge so a following write never re-raises the strobe at once
    endtask : wr

    // Data is registered, so it is taken one edge after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        re   = 1'b1;
        tick(1);
        re = 1'b0;
        tick(1);
        chk($sformatf("reg %h", a), 20'(exp), 20'(rdata));
    endtask : rdchk

    task automatic measure(input logic [15:0] v);
        mval = v;
        mreq = 1'b1;
        tick(1);
        mreq = 1'b0;
        tick(2);
    endtask : measure

    // Waits are bounded; running out ends the run as a mismatch
    task automatic wait_busy(input logic lvl_want, input int bound);
        int n;
        n = 0;
        while (busy !== lvl_want && n < bound) begin
            tick(1);
            n++;
        end
        if (busy !== lvl_want) begin
            err_total++;
            $display("BAD busy expected %b seen %b", lvl_want, busy);
            finish_test();
        end
    endtask : wait_busy

    // A second play request in mid-run must not restart the sequence
    task automatic run_play;
        play = 1'b1;
        tick(1);
        play = 1'b0;
        wait_busy(1'b1, 10);
        tick(5);
        play = 1'b1;
        tick(1);
        play = 1'b0;
        wait_busy(1'b0, 3000);
        tick(2);
    endtask : run_play

    initial begin
        logic [7:0] v;
        {rst_i, we, re, det_en, play, mreq} = 6'b100000;
        {addr, wdata, mval} = '0;
        supply = '0;
        repeat (5) @(posedge clock_i);
        #1 rst_i = 1'b0;
        // Reset values of the whole map
        for (int i = 0; i < 11; i++) rdchk(RA[i], RV[i]);
        // Write-back of every writable register; reserved bit of the second level stays 0
        for (int i = 0; i < 9; i++) begin
            v = 8'h5a ^ 8'(i * 17);
            wr(RA[i], v);
            rdchk(RA[i], (RA[i] == ADR_LVL2) ? (v & 8'h7f) : v);
        end
        wr(ADR_FREQ_HI, 8'hff);
        wr(ADR_FREQ_LO, 8'hff);
        wr(8'h23, 8'h77);
        rdchk(ADR_FREQ_HI, 8'h00);
        rdchk(ADR_FREQ_LO, 8'h00);
        rdchk(8'h23, 8'h00);
        // Exported preset half period and tracking margin in clock cycles
        wr(ADR_PRESET, 8'h10);
        wr(ADR_MARGIN, 8'h05);
        tick(2);
        chk("preset", 20'(16 * UNIT), preset_cyc);
        chk("margin", 20'd1040, 20'(margin_cyc));
        // Brake gain nibble follows boost select
        wr(ADR_BRKGAIN, 8'h3a);
        tick(2);
        chk("gain plain", 20'ha, 20'(gain));
        supply.boost_select = 1'b1;
        tick(2);
        chk("gain boost", 20'h3, 20'(gain));
        supply.boost_select = 1'b0;
        // Measurements count only while detection is enabled
        measure(16'h1234);
        rdchk(ADR_FREQ_HI, 8'h00);
        chk("detect off", 20'h0, 20'(det_act));
        det_en = 1'b1;
        tick(2);
        chk("detect on", 20'h1, 20'(det_act));
        measure(16'h1234);
        rdchk(ADR_FREQ_HI, 8'h12);
        rdchk(ADR_FREQ_LO, 8'h34);
        // Playback with tracking off: half width 3 units stays under the preset half period
        wr(ADR_HWIDTH, 8'h03);
        wr(ADR_CNT1, 8'h03);
        wr(ADR_CNT2, 8'h02);
        wr(ADR_CNTBRK, 8'h04);
        wr(ADR_TRKLVL1, 8'h40);
        wr(ADR_LVL2, 8'h20);
        supply.supply_rail = 8'hc8;
        run_play();
        chk("halves 1", 20'd3, 20'(halves[1]));
        chk("halves 2", 20'd2, 20'(halves[2]));
        chk("halves brk", 20'd4, 20'(halves[3]));
        chk("level 1", 20'h64, 20'(lvl[1]));
        chk("level 2", 20'h32, 20'(lvl[2]));
        chk("level brk", 20'h0, 20'(lvl[3]));
        chk("gap drive", 20'(3 * UNIT + 2), 20'(gap_drv));
        chk("gap brake", 20'(3 * UNIT + 2), 20'(gap_brk));
        // Playback with tracking on and battery compensation, one level clamped
        wr(ADR_TRKLVL1, 8'hf0);
        supply.vbat_comp = 1'b1;
        supply.vbat_ref = 8'h80;
        supply.vbat = 8'h40;
        run_play();
        chk("level 1 clamp", 20'hc8, 20'(lvl[1]));
        chk("level 2 comp", 20'h20, 20'(lvl[2]));
        chk("gap tracked", 20'd11, 20'(gap_drv));
        chk("gap brake", 20'(3 * UNIT + 2), 20'(gap_brk));
        chk("halves 1", 20'd3, 20'(halves[1]));
        // Boosted playback ignores compensation and uses the rail formula
        supply.boost_select = 1'b1;
        run_play();
        chk("level 1 boost", 20'haf, 20'(lvl[1]));
        chk("level 2 boost", 20'h32, 20'(lvl[2]));
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
